// [dram_page_mode_controller.sv]
`timescale 1ns/10ps
module dram_page_mode_controller
    import dram_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ale_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic same_page_write_hint_n,
    input wire logic cs_n,
    input wire logic msel_n,
    input wire logic [25:0] ad_in,
    input wire logic [1:0] addr_lo,
    output logic [10:0] dram_addr_bus,
    output logic [3:0] ras_n,
    output logic [3:0] cas_n,
    output logic we_n,
    output logic ack_n,
    output logic ack_oe,
    output logic read_buffer_enable_n,
    output logic read_buffer_enable_oe,
    output logic [1:0] xcvr_oe_n,
    output logic xcvr_to_cpu
);
    logic [1:0] rst_sync_r;
    logic rst_n;

    ctrl_state_type state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [25:0] addr_r, addr_nxt;
    logic [3:0] be_n_r, be_n_nxt;
    logic [1:0] wcnt_r, wcnt_nxt;
    logic ale_q_r, ale_q_nxt;
    logic acc_pend_r, acc_pend_nxt;
    logic is_write_r, is_write_nxt;
    logic is_burst_r, is_burst_nxt;
    logic ras_open_r, ras_open_nxt;
    logic need_row_r, need_row_nxt;
    logic own_r, own_nxt;
    logic [12:0] open_page_r, open_page_nxt;
    logic ref_pend_r, ref_pend_nxt;
    logic [3:0] init_ref_r, init_ref_nxt;
    logic [3:0] ras_n_r, ras_n_nxt;
    logic [3:0] cas_n_r, cas_n_nxt;
    logic we_n_r, we_n_nxt;
    logic ack_n_r, ack_n_nxt;
    logic rbe_n_r, rbe_n_nxt;
    logic hs_oe_r, hs_oe_nxt;
    logic [1:0] xoe_n_r, xoe_n_nxt;
    logic to_cpu_r, to_cpu_nxt;
    logic [10:0] addr_out_r;

    logic [10:0] map_row, map_col, col_eff;
    logic [1:0] map_bank;
    logic [12:0] map_page;
    logic refresh_tick;
    logic [2:0] ras_w, ras_pre, cas_w, cas_pre;
    logic [3:0] ras_sel;
    logic use_col;
    logic inter;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    dram_addr_map u_addr_map (
        .addr(addr_r),
        .page_size_sel(cfg_r[CFG_PAGE_LSB+1:CFG_PAGE_LSB]),
        .interleave(cfg_r[CFG_INTERLEAVE]),
        .row(map_row),
        .col(map_col),
        .bank(map_bank),
        .page_key(map_page)
    );

    refresh_timer #(.WIDTH(TIMER_W)) u_refresh_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .refresh_freq_sel(cfg_r[CFG_REFRESH_LSB+2:CFG_REFRESH_LSB]),
        .refresh_tick(refresh_tick)
    );

    always_comb begin
        inter = cfg_r[CFG_INTERLEAVE];
        {ras_w, ras_pre} = ras_timing(cfg_r[CFG_ROW_TIMING_LSB+2:CFG_ROW_TIMING_LSB]);
        cas_w = cfg_r[CFG_COL_WIDTH] ? CAS_WIDTH_SHORT : CAS_WIDTH_LONG;
        cas_pre = cfg_r[CFG_COL_PRECHARGE] ? CAS_PRE_LONG : CAS_PRE_SHORT;
        // Word within the quad replaces the low column bits
        col_eff = map_col;
        if (inter) begin
            col_eff[0] = wcnt_r[1];
        end else begin
            col_eff[1:0] = wcnt_r;
        end
        if (inter) begin
            ras_sel = map_bank[1] ? 4'hC : 4'h3;
        end else begin
            ras_sel = 4'h1 << map_bank;
        end
        use_col = (state_r == ST_COLSET) || (state_r == ST_CAS) || (state_r == ST_CASPRE)
            || (state_r == ST_OPEN) || ((state_r == ST_ROW) && (cnt_r == 3'h0));
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
        cfg_nxt = cfg_r;
        addr_nxt = addr_r;
        be_n_nxt = be_n_r;
        wcnt_nxt = wcnt_r;
        ale_q_nxt = ale_n;
        acc_pend_nxt = acc_pend_r;
        is_write_nxt = is_write_r;
        is_burst_nxt = is_burst_r;
        ras_open_nxt = ras_open_r;
        need_row_nxt = need_row_r;
        own_nxt = own_r;
        open_page_nxt = open_page_r;
        ref_pend_nxt = ref_pend_r;
        init_ref_nxt = init_ref_r;
        ras_n_nxt = ras_n_r;
        cas_n_nxt = cas_n_r;
        we_n_nxt = we_n_r;
        ack_n_nxt = 1'b1;
        rbe_n_nxt = 1'b1;
        xoe_n_nxt = 2'h3;
        to_cpu_nxt = to_cpu_r;
        if (!ale_n) begin
            addr_nxt = {ad_in[25:4], addr_lo, 2'h0};
            be_n_nxt = ad_in[3:0];
            wcnt_nxt = addr_lo;
        end
        if (!ale_q_r && ale_n) begin
            acc_pend_nxt = 1'b1;
        end
        if (refresh_tick || (init_ref_r != 4'h0)) begin
            ref_pend_nxt = 1'b1; // ST_REF_CAS below overrides this set, keeping it only when refresh_tick is high
        end
        case (state_r)
            ST_IDLE: begin
                if (ref_pend_r) begin
                    state_nxt = ST_REF_CAS;
                end else if (acc_pend_r) begin
                    state_nxt = ST_DECODE;
                    cnt_nxt = cfg_r[CFG_DELAYED_SEL] ? 3'h1 : 3'h0;
                end
            end
            ST_OPEN: begin
                if (ref_pend_r) begin
                    state_nxt = ST_PRECHARGE;
                    ras_n_nxt = 4'hF;
                    ras_open_nxt = 1'b0;
                    cnt_nxt = ras_pre - 3'h1;
                end else if (acc_pend_r) begin
                    state_nxt = ST_DECODE;
                    cnt_nxt = cfg_r[CFG_DELAYED_SEL] ? 3'h1 : 3'h0;
                end
            end
            ST_DECODE: begin
                if (cnt_r != 3'h0) begin
                    state_nxt = ST_DECODE;
                end else if (cs_n) begin
                    acc_pend_nxt = 1'b0;
                    state_nxt = ras_open_r ? ST_OPEN : ST_IDLE;
                end else if (!rd_n || !wr_n) begin
                    acc_pend_nxt = 1'b0;
                    own_nxt = 1'b1;
                    is_write_nxt = !wr_n;
                    is_burst_nxt = !rd_n && !same_page_write_hint_n;
                    if (!rd_n && !same_page_write_hint_n) begin
                        wcnt_nxt = 2'h0; // Refill counts its own four words from zero
                    end
                    we_n_nxt = wr_n;
                    to_cpu_nxt = !rd_n;
                    if (!msel_n) begin
                        state_nxt = ST_MODE;
                        cnt_nxt = MODE_WRITE_CYCLES - 3'h1;
                    end else if (ras_open_r && ((map_page == open_page_r)
                        || (!wr_n && !same_page_write_hint_n && !cfg_r[CFG_NEAR_WR_DIS]))) begin
                        state_nxt = ST_COLSET;
                    end else if (ras_open_r) begin
                        state_nxt = ST_PRECHARGE;
                        need_row_nxt = 1'b1;
                        ras_n_nxt = 4'hF;
                        ras_open_nxt = 1'b0;
                        cnt_nxt = ras_pre - 3'h1;
                    end else begin
                        state_nxt = ST_ROW;
                        ras_n_nxt = ~ras_sel;
                        cnt_nxt = cfg_r[CFG_RCD] ? 3'h1 : 3'h0;
                    end
                end
            end
            ST_ROW, ST_COLSET: begin
                if (state_r == ST_COLSET || cnt_r == 3'h0) begin
                    state_nxt = ST_CAS;
                    cnt_nxt = cas_w - 3'h1;
                    cas_n_nxt = is_write_r ? be_n_r : 4'h0;
                    xoe_n_nxt = inter ? (wcnt_r[0] ? 2'h1 : 2'h2) : 2'h2;
                end
            end
            ST_CAS: begin
                xoe_n_nxt = xoe_n_r;
                if (cnt_r == 3'h1 || cas_w == 3'h1) begin
                    rbe_n_nxt = is_write_r;
                    ack_n_nxt = !(is_write_r || !is_burst_r || wcnt_r == BURST_WORDS_LAST);
                end
                if (cnt_r == 3'h0) begin
                    cas_n_nxt = 4'hF;
                    xoe_n_nxt = 2'h3;
                    if (is_burst_r && wcnt_r != BURST_WORDS_LAST) begin
                        state_nxt = ST_CASPRE;
                        wcnt_nxt = wcnt_r + 2'h1;
                        cnt_nxt = cas_pre - 3'h1;
                    end else if (is_burst_r) begin
                        state_nxt = ST_PRECHARGE;
                        ras_n_nxt = 4'hF;
                        ras_open_nxt = 1'b0;
                        own_nxt = 1'b0;
                        we_n_nxt = 1'b1;
                        cnt_nxt = ras_pre - 3'h1;
                    end else begin
                        state_nxt = ST_OPEN;
                        ras_open_nxt = 1'b1;
                        open_page_nxt = map_page;
                        own_nxt = 1'b0;
                        we_n_nxt = 1'b1;
                    end
                end
            end
            ST_CASPRE: begin
                if (cnt_r == 3'h0) begin
                    state_nxt = ST_CAS;
                    cnt_nxt = cas_w - 3'h1;
                    cas_n_nxt = 4'h0;
                    xoe_n_nxt = inter ? (wcnt_r[0] ? 2'h1 : 2'h2) : 2'h2;
                end
            end
            ST_PRECHARGE: begin
                if (cnt_r == 3'h0) begin
                    cas_n_nxt = 4'hF;
                    if (need_row_r) begin
                        state_nxt = ST_ROW; // Access began before refresh asked
                        need_row_nxt = 1'b0;
                        ras_n_nxt = ~ras_sel;
                        cnt_nxt = cfg_r[CFG_RCD] ? 3'h1 : 3'h0;
                    end else if (ref_pend_r) begin
                        state_nxt = ST_REF_CAS;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_REF_CAS: begin
                state_nxt = ST_REF_RAS;
                cas_n_nxt = 4'h0;
                ref_pend_nxt = refresh_tick;
                if (init_ref_r != 4'h0) begin
                    init_ref_nxt = init_ref_r - 4'h1;
                end
            end
            ST_REF_RAS: begin
                state_nxt = ST_PRECHARGE;
                ras_n_nxt = 4'h0;
                cnt_nxt = ras_w;
            end
            ST_MODE: begin
                if (cnt_r == 3'h0) begin
                    cfg_nxt = ad_in[15:0] & ~CFG_RESERVED_MASK;
                    ack_n_nxt = 1'b0;
                    own_nxt = 1'b0;
                    we_n_nxt = 1'b1;
                    state_nxt = ras_open_r ? ST_OPEN : ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Refresh RAS phase must end as its counted width runs out
        if (state_r == ST_PRECHARGE && cnt_r != 3'h0 && !ras_open_r && cas_n_r == 4'h0
            && cnt_r == 3'h1) begin
            ras_n_nxt = 4'hF;
        end
        hs_oe_nxt = own_nxt || own_r;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            cfg_r <= CFG_RESET;
            addr_r <= 26'h0;
            be_n_r <= 4'hF;
            wcnt_r <= 2'h0;
            ale_q_r <= 1'b1;
            acc_pend_r <= 1'b0;
            is_write_r <= 1'b0;
            is_burst_r <= 1'b0;
            ras_open_r <= 1'b0;
            need_row_r <= 1'b0;
            own_r <= 1'b0;
            open_page_r <= 13'h0;
            ref_pend_r <= 1'b0;
            init_ref_r <= INIT_REFRESH_COUNT;
            ras_n_r <= 4'hF;
            cas_n_r <= 4'hF;
            we_n_r <= 1'b1;
            ack_n_r <= 1'b1;
            rbe_n_r <= 1'b1;
            hs_oe_r <= 1'b0;
            xoe_n_r <= 2'h3;
            to_cpu_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cfg_r <= cfg_nxt;
            addr_r <= addr_nxt;
            be_n_r <= be_n_nxt;
            wcnt_r <= wcnt_nxt;
            ale_q_r <= ale_q_nxt;
            acc_pend_r <= acc_pend_nxt;
            is_write_r <= is_write_nxt;
            is_burst_r <= is_burst_nxt;
            ras_open_r <= ras_open_nxt;
            need_row_r <= need_row_nxt;
            own_r <= own_nxt;
            open_page_r <= open_page_nxt;
            ref_pend_r <= ref_pend_nxt;
            init_ref_r <= init_ref_nxt;
            ras_n_r <= ras_n_nxt;
            cas_n_r <= cas_n_nxt;
            we_n_r <= we_n_nxt;
            ack_n_r <= ack_n_nxt;
            rbe_n_r <= rbe_n_nxt;
            hs_oe_r <= hs_oe_nxt;
            xoe_n_r <= xoe_n_nxt;
            to_cpu_r <= to_cpu_nxt;
        end
    end

    // Falling edge gives the half cycle of column setup before CAS
    always_ff @(negedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_out_r <= 11'h0;
        end else begin
            addr_out_r <= use_col ? col_eff : map_row;
        end
    end

    assign dram_addr_bus = addr_out_r;
    assign ras_n = ras_n_r;
    assign cas_n = cas_n_r;
    assign we_n = we_n_r;
    assign ack_n = ack_n_r;
    assign ack_oe = hs_oe_r;
    assign read_buffer_enable_n = rbe_n_r;
    assign read_buffer_enable_oe = hs_oe_r;
    assign xcvr_oe_n = xoe_n_r;
    assign xcvr_to_cpu = to_cpu_r;

endmodule : dram_page_mode_controller

// [dram_ctrl_pkg.sv]
package dram_ctrl_pkg;

    localparam int CFG_W = 16;
    localparam logic [15:0] CFG_RESET = 16'h6CB0;
    localparam logic [15:0] CFG_RESERVED_MASK = 16'h8200;
    localparam int CFG_PAGE_LSB = 0;
    localparam int CFG_INTERLEAVE = 2;
    localparam int CFG_NEAR_WR_DIS = 3;
    localparam int CFG_RCD = 4;
    localparam int CFG_ROW_TIMING_LSB = 5;
    localparam int CFG_COL_WIDTH = 8;
    localparam int CFG_COL_PRECHARGE = 10;
    localparam int CFG_REFRESH_LSB = 11;
    localparam int CFG_DELAYED_SEL = 14;

    localparam int CLK_PERIOD_NS = 25;
    localparam int RAS_MAX_LOW_NS = 10000;
    localparam logic [3:0] INIT_REFRESH_COUNT = 4'hF;
    localparam logic [2:0] MODE_WRITE_CYCLES = 3'h3;
    localparam logic [1:0] BURST_WORDS_LAST = 2'h3;
    // Half-cycle CAS figures are served in whole cycles, rounded up
    localparam logic [2:0] CAS_WIDTH_LONG = 3'h3;
    localparam logic [2:0] CAS_WIDTH_SHORT = 3'h2;
    localparam logic [2:0] CAS_PRE_SHORT = 3'h1;
    localparam logic [2:0] CAS_PRE_LONG = 3'h2;
    localparam int TIMER_W = 9;

    typedef enum logic [10:0] {
        ST_IDLE      = 11'h001,
        ST_DECODE    = 11'h002,
        ST_ROW       = 11'h004,
        ST_COLSET    = 11'h008,
        ST_CAS       = 11'h010,
        ST_CASPRE    = 11'h020,
        ST_OPEN      = 11'h040,
        ST_PRECHARGE = 11'h080,
        ST_REF_CAS   = 11'h100,
        ST_REF_RAS   = 11'h200,
        ST_MODE      = 11'h400
    } ctrl_state_type;

    function automatic logic [8:0] refresh_reload(input logic [2:0] sel);
        case (sel)
            3'h0: refresh_reload = 9'h017;
            3'h1: refresh_reload = 9'h03F;
            3'h2: refresh_reload = 9'h067;
            3'h3: refresh_reload = 9'h08F;
            3'h4: refresh_reload = 9'h0B0;
            3'h5: refresh_reload = 9'h0E2;
            3'h6: refresh_reload = 9'h133;
            default: refresh_reload = 9'h176;
        endcase
    endfunction : refresh_reload

    // Returns {pulse width, precharge} in cycles; reserved codes take the slowest
    function automatic logic [5:0] ras_timing(input logic [2:0] sel);
        case (sel)
            3'h0: ras_timing = {3'h2, 3'h2};
            3'h1: ras_timing = {3'h3, 3'h2};
            3'h2: ras_timing = {3'h3, 3'h3};
            3'h3: ras_timing = {3'h4, 3'h2};
            3'h4: ras_timing = {3'h4, 3'h3};
            default: ras_timing = {3'h4, 3'h4};
        endcase
    endfunction : ras_timing

endpackage : dram_ctrl_pkg

// [dram_addr_map.sv]
`timescale 1ns/10ps
module dram_addr_map
    import dram_ctrl_pkg::*;
(
    input wire logic [25:0] addr,
    input wire logic [1:0] page_size_sel,
    input wire logic interleave,
    output logic [10:0] row,
    output logic [10:0] col,
    output logic [1:0] bank,
    output logic [12:0] page_key
);
    logic [1:0] step;
    logic [10:0] mask;
    logic [25:0] col_sh;
    logic [25:0] row_sh;
    logic [25:0] bank_sh;

    always_comb begin
        step = (page_size_sel == 2'h3) ? 2'h2 : ((page_size_sel == 2'h0) ? 2'h0 : 2'h1);
        mask = 11'h1FF | ((step != 2'h0) ? 11'h200 : 11'h000) | ((step == 2'h2) ? 11'h400 : 11'h000);
        // Interleave moves every field up one bit; each density step moves the row up one bit and the bank up two
        col_sh = addr >> (5'd2 + 5'(interleave));
        row_sh = addr >> (5'd11 + 5'(step) + 5'(interleave));
        bank_sh = addr >> (5'd20 + 5'({step, 1'b0}) + 5'(interleave));
        col = col_sh[10:0] & mask;
        row = row_sh[10:0] & mask;
        // Interleaved: high bit picks the bank pair, word bit picks the array
        bank = interleave ? {bank_sh[0], addr[2]} : bank_sh[1:0];
        page_key = {bank[1], interleave ? 1'b0 : bank[0], row};
    end

endmodule : dram_addr_map

// [refresh_timer.sv]
`timescale 1ns/10ps
module refresh_timer
    import dram_ctrl_pkg::*;
#(
    parameter int WIDTH = TIMER_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] refresh_freq_sel,
    output logic refresh_tick
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic tick_r;
    logic tick_nxt;

    if (WIDTH < TIMER_W) begin : g_width_chk
        $error("refresh_timer: WIDTH too small for reload table");
    end

    always_comb begin
        tick_nxt = 1'b0;
        count_nxt = count_r - 1'b1;
        if (count_r == '0) begin
            tick_nxt = 1'b1;
            count_nxt = WIDTH'(refresh_reload(refresh_freq_sel));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            tick_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign refresh_tick = tick_r;

endmodule : refresh_timer

// [dram_ctrl_chk.sv]
`timescale 1ns/10ps
module dram_ctrl_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] ras_n,
    input wire logic [3:0] cas_n,
    input wire logic ack_n,
    input wire logic ack_oe,
    input wire logic read_buffer_enable_n,
    input wire logic read_buffer_enable_oe,
    input wire logic [1:0] xcvr_oe_n,
    input wire logic xcvr_to_cpu
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic cbr;
    // Refresh opens with every CAS low and no RAS yet
    assign cbr = (cas_n == 4'h0) && (ras_n == 4'hF);
    a_ack_drive: assert property (!ack_n |-> ack_oe)
        else $error("ack low while undriven");
    a_rbe_drive: assert property (!read_buffer_enable_n |-> read_buffer_enable_oe)
        else $error("read strobe low while undriven");
    a_ack_one_cycle: assert property (!ack_n |=> ack_n)
        else $error("ack held too long");
    a_cbr_order: assert property (cbr && $past(cas_n) == 4'hF |=> ras_n == 4'h0)
        else $error("refresh RAS not after CAS");
    a_cas_under_ras: assert property (cas_n != 4'hF |-> ras_n != 4'hF || cas_n == 4'h0)
        else $error("access CAS without RAS");
    a_ras_to_cas: assert property ($past(ras_n) == 4'hF && ras_n != 4'hF && cas_n == 4'hF
        |-> ##[1:2] cas_n != 4'hF)
        else $error("RAS to CAS gap wrong");
    a_read_dir: assert property (!read_buffer_enable_n |-> xcvr_to_cpu && xcvr_oe_n != 2'h3)
        else $error("read data path not open");
    a_refresh_quiet: assert property (cbr |-> read_buffer_enable_n)
        else $error("read strobe during refresh");
    c_refresh: cover property (cbr);
    c_read: cover property (!read_buffer_enable_n);
    c_ack: cover property (!ack_n);
endmodule : dram_ctrl_chk

bind dram_page_mode_controller dram_ctrl_chk chk (.ref_clk(ref_clk), .resetn(resetn),
    .ras_n(ras_n), .cas_n(cas_n), .ack_n(ack_n), .ack_oe(ack_oe),
    .read_buffer_enable_n(read_buffer_enable_n), .read_buffer_enable_oe(read_buffer_enable_oe),
    .xcvr_oe_n(xcvr_oe_n), .xcvr_to_cpu(xcvr_to_cpu));

// [cpu_bus_model.sv]
`timescale 1ns/10ps
module cpu_bus_model (
    input wire logic ref_clk,
    input wire logic ack_n,
    output logic ale_n,
    output logic rd_n,
    output logic wr_n,
    output logic hint_n,
    output logic cs_n,
    output logic msel_n,
    output logic [25:0] ad_in,
    output logic [1:0] addr_lo
);
    initial begin
        {ale_n, rd_n, wr_n, hint_n, cs_n, msel_n} = 6'h3F;
        ad_in = 26'h0000000;
        addr_lo = 2'h0;
    end
    // Strobes held until the edge that samples ack, or for 60 edges without one; released bus shows inverted data
    task automatic access(input logic rd, mode, hint, sel, input logic [25:0] a,
        input logic [3:0] be, input logic [1:0] lo, output logic acked);
        int i;
        acked = 1'b0;
        @(posedge ref_clk);
        #2;
        ale_n = 1'b0;
        ad_in = {a[25:4], be};
        addr_lo = lo;
        @(posedge ref_clk);
        #2;
        ale_n = 1'b1;
        rd_n = !rd;
        wr_n = rd;
        hint_n = !hint;
        cs_n = !sel;
        msel_n = !mode;
        ad_in = rd ? ~ad_in : a;
        for (i = 0; i < 60 && !acked; i++) begin
            @(posedge ref_clk);
            acked = (ack_n === 1'b0);
        end
        #2;
        {rd_n, wr_n, hint_n, cs_n, msel_n} = 5'h1F;
        ad_in = ~ad_in;
    endtask : access
endmodule : cpu_bus_model

// [dram_page_mode_controller_test.sv]
`timescale 1ns/10ps
module dram_page_mode_controller_test;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic ale_n, rd_n, wr_n, hint_n, cs_n, msel_n;
    logic [25:0] ad_in;
    logic [1:0] addr_lo, xcvr_oe_n;
    logic [10:0] dram_addr_bus, row_a, col_a;
    logic [3:0] ras_n, cas_n, ras_v, cas_acc;
    logic [3:0] prev_ras = 4'hF;
    logic [3:0] prev_cas = 4'hF;
    logic we_n, ack_n, ack_oe, rbe_n, rbe_oe, xcvr_to_cpu, ras_seen, cas_seen, acked;
    logic we_seen;
    int n_fail = 0;
    int compares = 0;
    int n_cbr = 0;
    int n_rbe, dly;

    always #12.5 ref_clk = ~ref_clk;

    cpu_bus_model cpu (.ref_clk(ref_clk), .ack_n(ack_n), .ale_n(ale_n), .rd_n(rd_n),
        .wr_n(wr_n), .hint_n(hint_n), .cs_n(cs_n), .msel_n(msel_n), .ad_in(ad_in),
        .addr_lo(addr_lo));

    dram_page_mode_controller dut (.ref_clk(ref_clk), .resetn(resetn), .ale_n(ale_n),
        .rd_n(rd_n), .wr_n(wr_n), .same_page_write_hint_n(hint_n), .cs_n(cs_n),
        .msel_n(msel_n), .ad_in(ad_in), .addr_lo(addr_lo), .dram_addr_bus(dram_addr_bus),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ack_n(ack_n), .ack_oe(ack_oe),
        .read_buffer_enable_n(rbe_n), .read_buffer_enable_oe(rbe_oe),
        .xcvr_oe_n(xcvr_oe_n), .xcvr_to_cpu(xcvr_to_cpu));

    // Stats of the latest access, refresh cycles kept apart
    always @(posedge ref_clk) begin
        if (rbe_n === 1'b0) n_rbe++;
        if (we_n === 1'b0) we_seen = 1'b1;
        if (cas_n == 4'h0 && prev_cas != 4'h0 && ras_n == 4'hF) n_cbr++;
        if (ras_n != 4'hF && ras_n != 4'h0) cas_acc = cas_acc & cas_n;
        if (ras_seen && !cas_seen) begin
            dly++;
            if (cas_n != 4'hF) begin
                cas_seen = 1'b1;
                col_a = dram_addr_bus;
            end
        end
        if (!ras_seen && prev_ras == 4'hF && ras_n != 4'hF && cas_n == 4'hF) begin
            ras_seen = 1'b1;
            ras_v = ras_n;
            row_a = dram_addr_bus;
            dly = 0;
        end
        prev_ras = ras_n;
        prev_cas = cas_n;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic run(input logic rd, mode, hint, sel, input logic [25:0] a,
        input logic [3:0] be, input logic [1:0] lo);
        ras_seen = 1'b0;
        cas_seen = 1'b0;
        n_rbe = 0;
        we_seen = 1'b0;
        cas_acc = 4'hF;
        cpu.access(rd, mode, hint, sel, a, be, lo, acked);
        repeat (2) @(posedge ref_clk);
        #2;
    endtask : run

    task automatic t_read_rcd2();
        run(1'b1, 1'b0, 1'b0, 1'b1, 26'h02AAAA0, 4'h0, 2'h1);
        chk({15'h0000, acked}, 16'h0001);
        chk({12'h000, ras_v}, 16'h000B);
        chk(16'(dly), 16'h0002);
        chk({7'h00, row_a[8:0]}, 16'h0155);
        chk({7'h00, col_a[8:0]}, 16'h00A9);
        chk(16'(n_rbe), 16'h0001);
        chk({12'h000, ras_n}, 16'h000B);
        chk({15'h0000, we_seen}, 16'h0000);
    endtask : t_read_rcd2

    task automatic t_page_write();
        run(1'b0, 1'b0, 1'b1, 1'b1, 26'h02AAAA0, 4'hA, 2'h1);
        chk({15'h0000, acked}, 16'h0001);
        chk({15'h0000, ras_seen}, 16'h0000);
        chk({12'h000, cas_acc}, 16'h000A);
        chk({15'h0000, we_seen}, 16'h0001);
    endtask : t_page_write

    task automatic t_rcd1_read();
        run(1'b0, 1'b1, 1'b0, 1'b1, 26'h0006CA0, 4'h0, 2'h0);
        chk({15'h0000, acked}, 16'h0001);
        run(1'b1, 1'b0, 1'b0, 1'b1, 26'h0001800, 4'h0, 2'h0);
        chk({12'h000, ras_v}, 16'h000E);
        chk(16'(dly), 16'h0001);
        chk({7'h00, col_a[8:0]}, 16'h0000);
    endtask : t_rcd1_read

    task automatic t_burst();
        run(1'b1, 1'b0, 1'b1, 1'b1, 26'h0001840, 4'h0, 2'h2);
        chk(16'(n_rbe), 16'h0004);
        chk({15'h0000, ras_seen}, 16'h0000);
        chk({8'h00, ras_n, cas_n}, 16'h00FF);
    endtask : t_burst

    task automatic t_interleave();
        run(1'b0, 1'b1, 1'b0, 1'b1, 26'h0002CA4, 4'h0, 2'h0);
        chk({15'h0000, acked}, 16'h0001);
        run(1'b1, 1'b0, 1'b0, 1'b1, 26'h0000000, 4'h0, 2'h0);
        chk({12'h000, ras_v}, 16'h000C);
        chk(16'(n_rbe), 16'h0001);
    endtask : t_interleave

    task automatic t_unselected();
        run(1'b1, 1'b0, 1'b0, 1'b0, 26'h02AAAA0, 4'h0, 2'h1);
        chk({15'h0000, acked}, 16'h0000);
        chk(16'(n_rbe), 16'h0000);
    endtask : t_unselected

    initial begin
        repeat (10) @(posedge ref_clk);
        #2 resetn = 1'b1;
        repeat (200) @(posedge ref_clk);
        chk(16'(n_cbr), 16'h000F);
        t_read_rcd2();
        t_page_write();
        t_rcd1_read();
        t_burst();
        t_interleave();
        t_unselected();
        finish_test();
    end
endmodule : dram_page_mode_controller_test
